// [design/clcc_pkg.sv]
// Purpose: shared constants and types for the charger/LED/converter config bank
// Assumes: 250 MHz core clock, byte-wide register port from the serial slave
// Notes: times kept in their own units, cycle counts derived here
package clcc_pkg;

    localparam int CLK_MHZ = 250;

    // Register byte addresses
    localparam logic [7:0] ADDR_CHARGER_CONFIG = 8'h07;
    localparam logic [7:0] ADDR_STATUS_LED_ON = 8'h08;
    localparam logic [7:0] ADDR_STATUS_LED_PER = 8'h09;
    localparam logic [7:0] ADDR_AUX_LED_ON = 8'h0A;
    localparam logic [7:0] ADDR_AUX_LED_PER = 8'h0B;
    localparam logic [7:0] ADDR_MAIN_CONV = 8'h0C;

    // Reset values
    localparam logic [7:0] RST_CHARGER_CONFIG = 8'h1B;
    localparam logic [7:0] RST_LED = 8'h00;
    localparam logic [7:0] RST_MAIN_CONV = 8'h72;

    // Field positions
    localparam int BIT_POR_SHORT = 7;
    localparam int BIT_CHG_RESTART = 6;
    localparam int BIT_FAST_TIMER = 5;
    localparam int BIT_CUR_HI = 4;
    localparam int BIT_CUR_LO = 3;
    localparam int BIT_USB_HIGH = 2;
    localparam int BIT_USB_ALLOW = 1;
    localparam int BIT_CHG_ENABLE = 0;
    localparam int BIT_LED_SELECT = 7;
    localparam int BIT_FORCED_PWM = 7;
    localparam int BIT_UV_HI = 6;
    localparam int BIT_UV_LO = 5;

    // Times in their own units
    localparam int POR_LONG_MS = 1000;
    localparam int POR_SHORT_MS = 69;
    localparam int ON_STEP_MS = 10;
    localparam int PER_STEP_MS = 100;

    // Cycle counts derived from the clock rate
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int POR_LONG_CYC = POR_LONG_MS * CYC_PER_MS;
    localparam int POR_SHORT_CYC = POR_SHORT_MS * CYC_PER_MS;
    localparam int ON_STEP_CYC = ON_STEP_MS * CYC_PER_MS;

    // Blink timing is a 10 ms tick; one period step is this many ticks
    localparam logic [3:0] PER_STEP_TICKS = 4'(PER_STEP_MS / ON_STEP_MS);

    typedef enum logic [1:0] {
        CLCC_CUR_25 = 2'h0,
        CLCC_CUR_50 = 2'h1,
        CLCC_CUR_75 = 2'h2,
        CLCC_CUR_FULL = 2'h3
    } clcc_current_t;

    typedef enum logic [1:0] {
        CLCC_UV_2V50 = 2'h0,
        CLCC_UV_2V75 = 2'h1,
        CLCC_UV_3V00 = 2'h2,
        CLCC_UV_3V25 = 2'h3
    } clcc_uvlo_t;

    // Charger-facing controls
    typedef struct packed {
        logic restart;
        logic fast_timer_en;
        clcc_current_t current_sel;
        logic usb_high_limit;
        logic usb_allowed;
        logic charge_enable;
        logic prefer_wall;
    } clcc_charger_ctl_t;

    // Converter-facing controls
    typedef struct packed {
        logic forced_fixed_frequency;
        clcc_uvlo_t uvlo_sel;
    } clcc_conv_ctl_t;

endpackage

// [design/clcc_blink.sv]
// Purpose: one LED blink generator with select modes
// Assumes: tick is a one-cycle pulse every 10 ms
// Notes: output is the open-drain transistor enable, high means pulled low
`timescale 1ns/100ps
module clcc_blink (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [1:0] select,
    input wire logic [1:0] blink_code,
    input wire logic [1:0] on_code,
    input wire logic follow_code_en,
    input wire logic follow_level,
    input wire logic [6:0] on_time,
    input wire logic [6:0] period,
    output logic drive_on
);

    logic [10:0] tick_reg;
    logic [10:0] tick_next;
    logic drive_next;
    logic [10:0] on_ticks;
    logic [10:0] per_ticks;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        on_ticks = 11'(on_time) + 11'h001;
        per_ticks = 11'(period) * 11'(clcc_pkg::PER_STEP_TICKS) +
            11'(clcc_pkg::PER_STEP_TICKS);
        tick_next = tick_reg;
        // Period restarts on wrap so a shortened period takes effect at once
        if (select != blink_code) begin
            tick_next = 11'h000;
        end else if (tick) begin
            if (tick_reg + 11'h001 >= per_ticks) begin
                tick_next = 11'h000;
            end else begin
                tick_next = tick_reg + 11'h001;
            end
        end
        if (follow_code_en && select == 2'h0) begin
            drive_next = follow_level;
        end else if (select == on_code) begin
            drive_next = 1'b1;
        end else if (select == blink_code) begin
            drive_next = tick_reg < on_ticks;
        end else begin
            drive_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_reg <= 11'h000;
            drive_on <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            drive_on <= drive_next;
        end
    end

endmodule

// [design/clcc_por_timer.sv]
// Purpose: power-on reset output pulse timer
// Assumes: rst is the device power-on reset
// Notes: length chosen from the select bit sampled while counting
`timescale 1ns/100ps
module clcc_por_timer #(
    parameter int LONG_CYC = clcc_pkg::POR_LONG_CYC,
    parameter int SHORT_CYC = clcc_pkg::POR_SHORT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic short_sel,
    output logic reset_active
);

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic active_next;
    logic [31:0] limit;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        limit = short_sel ? 32'(SHORT_CYC) : 32'(LONG_CYC);
        cnt_next = cnt_reg;
        active_next = reset_active;
        if (reset_active) begin
            if (cnt_reg + 32'h00000001 >= limit) begin
                active_next = 1'b0;
            end else begin
                cnt_next = cnt_reg + 32'h00000001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 32'h00000000;
            reset_active <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            reset_active <= active_next;
        end
    end

endmodule

// [design/clcc_top.sv]
// Purpose: charger, LED and main converter configuration register bank
// Assumes: byte register port driven by the serial slave, one access per strobe
// Notes: LED outputs are open-drain, given as output plus enable
`timescale 1ns/100ps
module clcc_top #(
    parameter int POR_LONG_CYC = clcc_pkg::POR_LONG_CYC,
    parameter int POR_SHORT_CYC = clcc_pkg::POR_SHORT_CYC,
    parameter int ON_STEP_CYC = clcc_pkg::ON_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic main_voltage_default_pin,
    input wire logic charger_led_request,
    input wire logic wall_valid,
    input wire logic usb_valid,
    output clcc_pkg::clcc_charger_ctl_t charger_ctl,
    output clcc_pkg::clcc_conv_ctl_t conv_ctl,
    output logic power_on_reset_output,
    output logic charge_status_output_o,
    output logic charge_status_output_oe,
    output logic aux_led_output_o,
    output logic aux_led_output_oe
);

    logic [7:0] chg_reg;
    logic [7:0] chg_next;
    logic [7:0] sled_on_reg;
    logic [7:0] sled_on_next;
    logic [7:0] sled_per_reg;
    logic [7:0] sled_per_next;
    logic [7:0] aled_on_reg;
    logic [7:0] aled_on_next;
    logic [7:0] aled_per_reg;
    logic [7:0] aled_per_next;
    logic [7:0] conv_reg;
    logic [7:0] conv_next;
    logic [7:0] rdata_next;
    logic hit_next;
    logic strap_done_reg;
    logic strap_done_next;
    logic restart_prev_reg;
    logic restart_prev_next;
    clcc_pkg::clcc_charger_ctl_t chg_ctl_next;
    clcc_pkg::clcc_conv_ctl_t conv_ctl_next;
    logic [31:0] tick_cnt_reg;
    logic [31:0] tick_cnt_next;
    logic tick_reg;
    logic tick_next;
    logic por_active;
    logic sled_drive;
    logic aled_drive;
    logic por_out_next;

    ////////////////////////////////////////////////////////////////////////
    // Register file
    always_comb begin
        chg_next = chg_reg;
        sled_on_next = sled_on_reg;
        sled_per_next = sled_per_reg;
        aled_on_next = aled_on_reg;
        aled_per_next = aled_per_reg;
        conv_next = conv_reg;
        strap_done_next = 1'b1;
        // Strap caught by a clock edge after release, never under reset
        if (!strap_done_reg) begin
            conv_next[0] = main_voltage_default_pin;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                clcc_pkg::ADDR_CHARGER_CONFIG: chg_next = reg_wdata;
                clcc_pkg::ADDR_STATUS_LED_ON: sled_on_next = reg_wdata;
                clcc_pkg::ADDR_STATUS_LED_PER: sled_per_next = reg_wdata;
                clcc_pkg::ADDR_AUX_LED_ON: aled_on_next = reg_wdata;
                clcc_pkg::ADDR_AUX_LED_PER: aled_per_next = reg_wdata;
                clcc_pkg::ADDR_MAIN_CONV: conv_next = reg_wdata;
                default: ;
            endcase
        end
        hit_next = 1'b1;
        unique case (reg_addr)
            clcc_pkg::ADDR_CHARGER_CONFIG: rdata_next = chg_reg;
            clcc_pkg::ADDR_STATUS_LED_ON: rdata_next = sled_on_reg;
            clcc_pkg::ADDR_STATUS_LED_PER: rdata_next = sled_per_reg;
            clcc_pkg::ADDR_AUX_LED_ON: rdata_next = aled_on_reg;
            clcc_pkg::ADDR_AUX_LED_PER: rdata_next = aled_per_reg;
            clcc_pkg::ADDR_MAIN_CONV: rdata_next = conv_reg;
            default: begin
                rdata_next = 8'h00;
                hit_next = 1'b0;
            end
        endcase
        if (!reg_rd && !reg_wr) begin
            rdata_next = reg_rdata;
            hit_next = reg_hit;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chg_reg <= clcc_pkg::RST_CHARGER_CONFIG;
            sled_on_reg <= clcc_pkg::RST_LED;
            sled_per_reg <= clcc_pkg::RST_LED;
            aled_on_reg <= clcc_pkg::RST_LED;
            aled_per_reg <= clcc_pkg::RST_LED;
            conv_reg <= clcc_pkg::RST_MAIN_CONV;
            strap_done_reg <= 1'b0;
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else begin
            chg_reg <= chg_next;
            sled_on_reg <= sled_on_next;
            sled_per_reg <= sled_per_next;
            aled_on_reg <= aled_on_next;
            aled_per_reg <= aled_per_next;
            conv_reg <= conv_next;
            strap_done_reg <= strap_done_next;
            reg_rdata <= rdata_next;
            reg_hit <= hit_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Charger and converter controls
    always_comb begin
        restart_prev_next = chg_reg[clcc_pkg::BIT_CHG_RESTART];
        // Either edge counts; host sets then clears, each edge restarts
        chg_ctl_next.restart = chg_reg[clcc_pkg::BIT_CHG_RESTART] ^
            restart_prev_reg;
        chg_ctl_next.fast_timer_en = chg_reg[clcc_pkg::BIT_FAST_TIMER];
        chg_ctl_next.current_sel = clcc_pkg::clcc_current_t'(
            {chg_reg[clcc_pkg::BIT_CUR_HI], chg_reg[clcc_pkg::BIT_CUR_LO]});
        chg_ctl_next.charge_enable = chg_reg[clcc_pkg::BIT_CHG_ENABLE];
        chg_ctl_next.usb_allowed = chg_reg[clcc_pkg::BIT_CHG_ENABLE] &
            chg_reg[clcc_pkg::BIT_USB_ALLOW];
        chg_ctl_next.usb_high_limit = chg_reg[clcc_pkg::BIT_USB_ALLOW] &
            chg_reg[clcc_pkg::BIT_USB_HIGH];
        chg_ctl_next.prefer_wall = chg_reg[clcc_pkg::BIT_CHG_ENABLE] & wall_valid &
            (usb_valid | 1'b1);
        conv_ctl_next.forced_fixed_frequency = conv_reg[clcc_pkg::BIT_FORCED_PWM];
        conv_ctl_next.uvlo_sel = clcc_pkg::clcc_uvlo_t'(
            {conv_reg[clcc_pkg::BIT_UV_HI], conv_reg[clcc_pkg::BIT_UV_LO]});
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            restart_prev_reg <= 1'b0;
            charger_ctl <= '0;
            conv_ctl <= '0;
        end else begin
            restart_prev_reg <= restart_prev_next;
            charger_ctl <= chg_ctl_next;
            conv_ctl <= conv_ctl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared 10 ms tick for both blink generators
    always_comb begin
        tick_next = 1'b0;
        tick_cnt_next = tick_cnt_reg + 32'h00000001;
        if (tick_cnt_reg + 32'h00000001 >= 32'(ON_STEP_CYC)) begin
            tick_cnt_next = 32'h00000000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    clcc_por_timer #(
        .LONG_CYC(POR_LONG_CYC),
        .SHORT_CYC(POR_SHORT_CYC)
    ) u_por (
        .clk(clk),
        .rst(rst),
        .short_sel(chg_reg[clcc_pkg::BIT_POR_SHORT]),
        .reset_active(por_active)
    );

    // Select code is {on-time bit 7, period bit 7}
    clcc_blink u_status_led (
        .clk(clk),
        .rst(rst),
        .tick(tick_reg),
        .select({sled_on_reg[clcc_pkg::BIT_LED_SELECT],
            sled_per_reg[clcc_pkg::BIT_LED_SELECT]}),
        .blink_code(2'h1),
        .on_code(2'h3),
        .follow_code_en(1'b1),
        .follow_level(charger_led_request),
        .on_time(sled_on_reg[6:0]),
        .period(sled_per_reg[6:0]),
        .drive_on(sled_drive)
    );

    clcc_blink u_aux_led (
        .clk(clk),
        .rst(rst),
        .tick(tick_reg),
        .select({aled_on_reg[clcc_pkg::BIT_LED_SELECT],
            aled_per_reg[clcc_pkg::BIT_LED_SELECT]}),
        .blink_code(2'h1),
        .on_code(2'h3),
        .follow_code_en(1'b0),
        .follow_level(1'b0),
        .on_time(aled_on_reg[6:0]),
        .period(aled_per_reg[6:0]),
        .drive_on(aled_drive)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered pin stage; open-drain pins only ever drive low
    always_comb begin
        por_out_next = por_active;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            power_on_reset_output <= 1'b1;
            charge_status_output_o <= 1'b0;
            charge_status_output_oe <= 1'b0;
            aux_led_output_o <= 1'b0;
            aux_led_output_oe <= 1'b0;
        end else begin
            power_on_reset_output <= por_out_next;
            charge_status_output_o <= 1'b0;
            charge_status_output_oe <= sled_drive;
            aux_led_output_o <= 1'b0;
            aux_led_output_oe <= aled_drive;
        end
    end

endmodule

// [sim/clcc_props.sv]
// Purpose: port-level assertions for the config bank
// Assumes: one clock, asynchronous active-high reset
// Notes: bound into clcc_top, sees its ports only
`timescale 1ns/100ps
module clcc_props #(
    parameter int POR_LONG_CYC = 200,
    parameter int POR_SHORT_CYC = 50,
    parameter int ON_STEP_CYC = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    input wire logic main_voltage_default_pin,
    input wire logic charger_led_request,
    input wire logic wall_valid,
    input wire logic usb_valid,
    input wire clcc_pkg::clcc_charger_ctl_t charger_ctl,
    input wire clcc_pkg::clcc_conv_ctl_t conv_ctl,
    input wire logic power_on_reset_output,
    input wire logic charge_status_output_o,
    input wire logic charge_status_output_oe,
    input wire logic aux_led_output_o,
    input wire logic aux_led_output_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    logic mapped;
    int por_cnt_reg;
    int por_cnt_next;
    assign mapped = (reg_addr >= 8'h07) && (reg_addr <= 8'h0C);
    // Saturates so a long run cannot wrap the count
    always_comb begin
        por_cnt_next = por_cnt_reg;
        if (por_cnt_reg < POR_LONG_CYC + 8) begin
            por_cnt_next = por_cnt_reg + 1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            por_cnt_reg <= 0;
        end else begin
            por_cnt_reg <= por_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_wr_idle_rd;
        reg_wr && mapped ##1 !reg_wr && !reg_rd
            ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2);
    endsequence
    sequence s_chg_write;
        reg_wr && reg_addr == 8'h07 ##1 !reg_wr;
    endsequence
    sequence s_conv_write;
        reg_wr && reg_addr == 8'h0C ##1 !reg_wr;
    endsequence

    a_read_unmapped: assert property
        (reg_rd && !mapped |=> reg_rdata == 8'h00 && !reg_hit)
        else $error("unmapped read gave data or hit");
    a_read_hit: assert property (reg_rd && mapped |=> reg_hit)
        else $error("mapped read without hit");
    a_write_readback: assert property
        (s_wr_idle_rd |=> reg_rdata == $past(reg_wdata, 3))
        else $error("read did not return last write");
    a_restart_single: assert property
        ($rose(charger_ctl.restart) |=> !charger_ctl.restart)
        else $error("restart pulse longer than one cycle");
    a_restart_cause: assert property
        (charger_ctl.restart |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h07)
        else $error("restart without charger config write");
    a_usb_needs_en: assert property
        (charger_ctl.usb_allowed |-> charger_ctl.charge_enable)
        else $error("usb charging allowed while charging disabled");
    // High limit depends on the permission bit only, not on charge enable
    a_usb_high_gate: assert property
        (s_chg_write |=> charger_ctl.usb_high_limit == $past(reg_wdata[2] & reg_wdata[1], 2))
        else $error("usb high limit does not follow its bits");
    a_wall_gate: assert property
        (charger_ctl.prefer_wall |-> charger_ctl.charge_enable)
        else $error("wall source chosen while charging disabled");
    a_chg_fields: assert property
        (s_chg_write |=> charger_ctl.fast_timer_en == $past(reg_wdata[5], 2)
        && charger_ctl.current_sel == $past(reg_wdata[4:3], 2))
        else $error("charger timer or current field wrong");
    a_conv_fields: assert property
        (s_conv_write |=> conv_ctl == $past(reg_wdata[7:5], 2))
        else $error("converter mode or threshold wrong");
    a_por_min: assert property (por_cnt_reg < POR_SHORT_CYC |-> power_on_reset_output)
        else $error("reset output ended too early");
    a_por_max: assert property
        (por_cnt_reg > POR_LONG_CYC + 2 |-> !power_on_reset_output)
        else $error("reset output too long");
    a_open_drain: assert property
        (!charge_status_output_o && !aux_led_output_o)
        else $error("open-drain output driven high");
endmodule

bind clcc_top clcc_props #(
    .POR_LONG_CYC(POR_LONG_CYC),
    .POR_SHORT_CYC(POR_SHORT_CYC),
    .ON_STEP_CYC(ON_STEP_CYC)
) clcc_props_inst (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
    .main_voltage_default_pin, .charger_led_request, .wall_valid, .usb_valid, .charger_ctl,
    .conv_ctl, .power_on_reset_output, .charge_status_output_o, .charge_status_output_oe,
    .aux_led_output_o, .aux_led_output_oe);

// [sim/clcc_host.sv]
// Purpose: host side of the byte register port
// Assumes: one access per task call, strobes one cycle wide
// Notes: drives 1 ns after the rising edge
`timescale 1ns/100ps
module clcc_host (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit
);
    initial begin
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // Byte-addressed write
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'h1;
        @(posedge clk);
        #1;
        reg_wr = 1'h0;
        // Stale data would hide a missed capture
        reg_wdata = ~data;
    endtask

    // Byte-addressed read, answer one edge after the strobe
    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic hit);
        @(posedge clk);
        #1;
        reg_addr = addr;
        reg_rd = 1'h1;
        @(posedge clk);
        #1;
        reg_rd = 1'h0;
        data = reg_rdata;
        hit = reg_hit;
    endtask
endmodule

// [sim/clcc_top_test.sv]
// Purpose: self-checking bench for the config bank
// Assumes: shortened counts, 10-cycle LED tick
// Notes: long reset check first, then table rows, then restart and short reset cases
`timescale 1ns/100ps
module clcc_top_test;
    localparam int LONG = 200;
    localparam int SHORT = 50;
    typedef struct {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;
        logic hit;} clcc_row_t;
    typedef struct {logic [7:0] base; logic [7:0] on; logic [7:0] per; logic req;
        int exp;} clcc_led_t;
    typedef struct {logic [7:0] data; logic wall; logic [7:0] exp;} clcc_chg_t;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic reg_wr, reg_rd, reg_hit, por, cs_o, cs_oe, aux_o, aux_oe, hit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic led_req = 1'h0;
    logic wall = 1'h1;
    clcc_pkg::clcc_charger_ctl_t charger_ctl;
    clcc_pkg::clcc_conv_ctl_t conv_ctl;
    int errors = 0;
    int n_tests = 0;
    int restarts = 0;
    clcc_row_t rows[15] = '{'{1'h0, 8'h07, 8'h00, 8'h1B, 1'h1},
        '{1'h0, 8'h08, 8'h00, 8'h00, 1'h1},
        '{1'h0, 8'h09, 8'h00, 8'h00, 1'h1}, '{1'h0, 8'h0A, 8'h00, 8'h00, 1'h1},
        '{1'h0, 8'h0B, 8'h00, 8'h00, 1'h1}, '{1'h0, 8'h0C, 8'h00, 8'h73, 1'h1},
        '{1'h0, 8'h06, 8'h00, 8'h00, 1'h0}, '{1'h1, 8'h08, 8'hA5, 8'hA5, 1'h1},
        '{1'h1, 8'h09, 8'h5A, 8'h5A, 1'h1}, '{1'h1, 8'h0A, 8'hFF, 8'hFF, 1'h1},
        '{1'h1, 8'h0B, 8'h81, 8'h81, 1'h1}, '{1'h1, 8'h0C, 8'h8D, 8'h8D, 1'h1},
        '{1'h1, 8'h07, 8'h9C, 8'h9C, 1'h1}, '{1'h1, 8'h0D, 8'h55, 8'h00, 1'h0},
        '{1'h1, 8'hFF, 8'h12, 8'h00, 1'h0}};
    // Window of 400 cycles holds whole periods, so the count is phase free
    clcc_led_t leds[11] = '{'{8'h0A, 8'h01, 8'h80, 1'h0, 80}, '{8'h0A, 8'h00, 8'h81, 1'h0, 20},
        '{8'h0A, 8'h7F, 8'h80, 1'h0, 400}, '{8'h0A, 8'h80, 8'h80, 1'h0, 400},
        '{8'h0A, 8'h85, 8'h03, 1'h1, 0}, '{8'h0A, 8'h05, 8'h03, 1'h1, 0},
        '{8'h08, 8'h00, 8'h00, 1'h1, 400}, '{8'h08, 8'h00, 8'h00, 1'h0, 0},
        '{8'h08, 8'h04, 8'h80, 1'h1, 200}, '{8'h08, 8'h80, 8'h00, 1'h1, 0},
        '{8'h08, 8'h80, 8'h80, 1'h0, 400}};
    clcc_chg_t chg[7] = '{'{8'h27, 1'h1, 8'h4F}, '{8'h2F, 1'h1, 8'h5F}, '{8'h37, 1'h1, 8'h6F},
        '{8'h3F, 1'h1, 8'h7F}, '{8'h06, 1'h1, 8'h08}, '{8'h05, 1'h1, 8'h03}, '{8'h03, 1'h0, 8'h06}};

    ////////////////////////////////////////////////////////////////////////////////
    clcc_top #(.POR_LONG_CYC(LONG), .POR_SHORT_CYC(SHORT), .ON_STEP_CYC(10)) clcc_top_inst (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .main_voltage_default_pin(1'h1), .charger_led_request(led_req), .wall_valid(wall),
        .usb_valid(1'h1), .charger_ctl(charger_ctl), .conv_ctl(conv_ctl),
        .power_on_reset_output(por), .charge_status_output_o(cs_o),
        .charge_status_output_oe(cs_oe), .aux_led_output_o(aux_o), .aux_led_output_oe(aux_oe));
    clcc_host clcc_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (charger_ctl.restart === 1'h1) begin
            restarts++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic led_row(input clcc_led_t r);
        int n;
        n = 0;
        led_req = r.req;
        clcc_host_inst.write_byte(r.base, r.on);
        clcc_host_inst.write_byte(r.base + 8'h01, r.per);
        repeat (300) @(posedge clk);
        repeat (400) begin
            // Sample settled outputs; also keeps the next row's drive off the edge
            wait_cyc(1);
            n += ((r.base == 8'h08) ? cs_oe : aux_oe) === 1'h1;
        end
        check(16'(n), 16'(r.exp));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        errors++;
        give_verdict();
    end

    initial begin
        wait_cyc(8);
        rst = 1'h0;
        wait_cyc(LONG - 20);
        check(16'(por), 16'h1);
        wait_cyc(30);
        check(16'(por), 16'h0);
        foreach (rows[i]) begin
            if (rows[i].wr === 1'h1) begin
                clcc_host_inst.write_byte(rows[i].addr, rows[i].data);
            end
            clcc_host_inst.read_byte(rows[i].addr, rd, hit);
            check(16'(rd), 16'(rows[i].exp));
            check(16'(hit), 16'(rows[i].hit));
        end
        foreach (chg[i]) begin
            wall = chg[i].wall;
            clcc_host_inst.write_byte(8'h07, chg[i].data);
            wait_cyc(3);
            check(16'(charger_ctl), 16'(chg[i].exp));
        end
        for (int u = 0; u < 4; u++) begin
            clcc_host_inst.write_byte(8'h0C, {u[0], u[1:0], 5'h13});
            wait_cyc(3);
            check(16'(conv_ctl), 16'({u[0], u[1:0]}));
        end
        foreach (leds[i]) begin
            led_row(leds[i]);
        end
        // Repeated set must not restart twice
        restarts = 0;
        clcc_host_inst.write_byte(8'h07, 8'h43);
        clcc_host_inst.write_byte(8'h07, 8'h43);
        clcc_host_inst.write_byte(8'h07, 8'h03);
        wait_cyc(4);
        check(16'(restarts), 16'h2);
        rst = 1'h1;
        wait_cyc(8);
        rst = 1'h0;
        clcc_host_inst.write_byte(8'h07, 8'h9B);
        wait_cyc(SHORT - 15);
        check(16'(por), 16'h1);
        wait_cyc(25);
        check(16'(por), 16'h0);
        give_verdict();
    end
endmodule
